// ---- core/byte_fifo.sv ----
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/100ps
module byte_fifo #(
  parameter int unsigned WIDTH = fault_signal_pkg::BYTE_W,
  parameter int unsigned DEPTH = fault_signal_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic             push;
  logic             pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign count_d  = count_q + CW'(push) - CW'(pop);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_d;
      inReady <= (count_d != CW'(DEPTH));
    end
  end

endmodule : byte_fifo

// ---- core/fault_event_encoder.sv ----
// Turns fault event pulses into a legacy code and extended flag bits.
`timescale 1ns/100ps
module fault_event_encoder #(
  parameter int unsigned NUM_EVENTS = fault_signal_pkg::NUM_EVENTS,
  parameter int unsigned FLAG_W     = fault_signal_pkg::FLAG_W
) (
  // Events
  input  wire logic [NUM_EVENTS-1:0] events,
  // Encoded result
  output logic                       anyEvent,
  output logic                       legacyEvent,
  output logic [7:0]                 legacyCode,
  output logic [FLAG_W-1:0]          flagBits
);

  // The highest numbered legacy event wins when several coincide.
  always_comb begin
    legacyEvent = 1'b0;
    legacyCode  = fault_signal_pkg::CODE_RESET;
    for (int i = 0; i < int'(fault_signal_pkg::NUM_LEGACY); i++) begin
      if (events[i]) begin
        legacyEvent = 1'b1;
        legacyCode  = fault_signal_pkg::LEGACY_CODE_TABLE[i];
      end
    end
  end

  assign anyEvent = |events;

  // One distinct flag bit per fault condition.
  assign flagBits = FLAG_W'(events);

endmodule : fault_event_encoder

// ---- core/fault_signal_pkg.sv ----
// Shared constants and types for the host fault and response signalling block.
package fault_signal_pkg;

  // ***************************************************************
  // Fault codes and event layout
  // ***************************************************************
  localparam int unsigned CODE_W      = 8;
  localparam int unsigned NUM_LEGACY  = 8;
  localparam int unsigned NUM_EVENTS  = 12;
  localparam int unsigned FLAG_W      = 16;

  localparam logic [7:0] INBOUND_OVERFLOW_CODE  = 8'h08;
  localparam logic [7:0] OUTBOUND_OVERFLOW_CODE = 8'h09;
  localparam logic [7:0] WRITE_FAILURE_CODE     = 8'h13;
  localparam logic [7:0] MISSING_ACK_CODE       = 8'h20;
  localparam logic [7:0] BODY_CHECKSUM_CODE     = 8'h40;
  localparam logic [7:0] HEADER_CHECKSUM_CODE   = 8'h42;
  localparam logic [7:0] ACK_SEQ_MISMATCH_CODE  = 8'h43;
  localparam logic [7:0] INVALID_FRAME_KIND_CODE = 8'h44;

  // Event index i carries the legacy code at entry i; higher events have none.
  localparam logic [7:0] LEGACY_CODE_TABLE [0:7] = '{
    INBOUND_OVERFLOW_CODE, OUTBOUND_OVERFLOW_CODE, WRITE_FAILURE_CODE,
    MISSING_ACK_CODE, BODY_CHECKSUM_CODE, HEADER_CHECKSUM_CODE,
    ACK_SEQ_MISMATCH_CODE, INVALID_FRAME_KIND_CODE
  };

  // ***************************************************************
  // Reset values and settings
  // ***************************************************************
  localparam logic [7:0]  CODE_RESET   = 8'h00;
  localparam logic [15:0] FLAGS_RESET  = 16'h0000;
  localparam logic [7:0]  HOLD_ENABLE  = 8'h01;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned FIFO_DEPTH   = 8;

  // ***************************************************************
  // Line status layout
  // ***************************************************************
  localparam int unsigned LSTAT_W          = 8;
  localparam int unsigned LSTAT_ALERT_BIT  = 0;
  localparam int unsigned LSTAT_SOURCE_BIT = 1;
  localparam int unsigned LSTAT_HOLD_BIT   = 2;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned DEFAULT_BAUD  = 9600;
  localparam int unsigned GUARD_BITS    = 10;
  localparam int unsigned BIT_CYCLES    = (CLK_HZ + DEFAULT_BAUD - 1) / DEFAULT_BAUD;
  localparam int unsigned GUARD_CYCLES_DEF = GUARD_BITS * BIT_CYCLES;

  typedef enum logic [1:0] {
    SRC_CMD     = 2'b00,
    SRC_DATA    = 2'b01,
    SRC_TO_DATA = 2'b10,
    SRC_TO_CMD  = 2'b11
  } src_state_t;

endpackage : fault_signal_pkg

// ---- core/host_fault_and_response_signalling.sv ----
// Fault alert engine and response source selection for the host serial link.
`timescale 1ns/100ps
module host_fault_and_response_signalling #(
  parameter int unsigned NUM_EVENTS   = fault_signal_pkg::NUM_EVENTS,
  parameter int unsigned FLAG_W       = fault_signal_pkg::FLAG_W,
  parameter int unsigned FIFO_DEPTH   = fault_signal_pkg::FIFO_DEPTH,
  parameter int unsigned GUARD_CYCLES = fault_signal_pkg::GUARD_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // Fault events, one cycle pulses
  input  wire logic [NUM_EVENTS-1:0] faultEvents,
  // Fault configuration and host access
  input  wire logic [7:0]            legacyFaultMask,
  input  wire logic [FLAG_W-1:0]     extendedFaultMask,
  input  wire logic                  legacyCodeRead,
  input  wire logic                  extFlagWrite,
  input  wire logic [FLAG_W-1:0]     extFlagWdata,
  // Fault outputs
  output logic                       faultAlertLine,
  output logic [7:0]                 legacyFaultCode,
  output logic [FLAG_W-1:0]          extendedFaultFlags,
  output logic [7:0]                 lineStatusRegister,
  // Mode inputs
  input  wire logic                  cmdSelectN,
  input  wire logic [7:0]            holdReceivedDuringCommand,
  input  wire logic                  cmdBusy,
  // Command response bytes
  input  wire logic                  cmdRespValid,
  input  wire logic [7:0]            cmdRespData,
  output logic                       cmdRespReady,
  // Received radio bytes
  input  wire logic                  rxValid,
  input  wire logic [7:0]            rxData,
  output logic                       rxReady,
  // Serial output towards the transmitter
  output logic                       outValid,
  output logic [7:0]                 outData,
  input  wire logic                  outReady,
  input  wire logic                  txBusy,
  output logic                       responseSourceLine
);

  localparam int unsigned GW = $clog2(GUARD_CYCLES + 1);

  // ***************************************************************
  // Fault engine
  // ***************************************************************
  logic              anyEvent;
  logic              legacyEvent;
  logic [7:0]        eventCode;
  logic [FLAG_W-1:0] eventFlags;
  logic              legacyAlert_q;
  logic              legacyAlert_d;
  logic [FLAG_W-1:0] flags_d;
  logic              extAlert_d;
  logic              alert_d;
  logic              legacyMode;

  fault_event_encoder #(
    .NUM_EVENTS (NUM_EVENTS),
    .FLAG_W     (FLAG_W)
  ) u_encoder (
    .events      (faultEvents),
    .anyEvent    (anyEvent),
    .legacyEvent (legacyEvent),
    .legacyCode  (eventCode),
    .flagBits    (eventFlags)
  );

  assign legacyMode = (legacyFaultMask != 8'h00);

  // A qualifying fault wins over a read in the same cycle.
  always_comb begin
    legacyAlert_d = legacyAlert_q;
    if (legacyCodeRead) begin
      legacyAlert_d = 1'b0;
    end
    if (legacyEvent && ((eventCode & legacyFaultMask) != 8'h00)) begin
      legacyAlert_d = 1'b1;
    end
  end

  // New fault bits win over a host write in the same cycle.
  always_comb begin
    flags_d = extFlagWrite ? extFlagWdata : extendedFaultFlags;
    flags_d = flags_d | eventFlags;
  end

  assign extAlert_d = ((flags_d & extendedFaultMask) != '0);
  assign alert_d    = legacyMode ? legacyAlert_d : extAlert_d;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      legacyAlert_q <= 1'b0;
      faultAlertLine <= 1'b0;
    end else begin
      legacyAlert_q <= legacyAlert_d;
      faultAlertLine <= alert_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      legacyFaultCode <= fault_signal_pkg::CODE_RESET;
    end else if (legacyEvent) begin
      legacyFaultCode <= eventCode;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      extendedFaultFlags <= fault_signal_pkg::FLAGS_RESET;
    end else begin
      extendedFaultFlags <= flags_d;
    end
  end

  // ***************************************************************
  // Received data buffer
  // ***************************************************************
  logic       fifoValid;
  logic [7:0] fifoData;
  logic       fifoPop;
  logic       holdActive;

  byte_fifo #(
    .WIDTH (fault_signal_pkg::BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .inValid  (rxValid),
    .inData   (rxData),
    .inReady  (rxReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoPop)
  );

  // Received data is held while the select line is low and holdReceivedDuringCommand equals HOLD_ENABLE.
  assign holdActive = (holdReceivedDuringCommand == fault_signal_pkg::HOLD_ENABLE)
                      && !cmdSelectN;

  // ***************************************************************
  // Response source selection
  // ***************************************************************
  fault_signal_pkg::src_state_t state_q;
  fault_signal_pkg::src_state_t state_d;
  logic [GW-1:0] guardCnt_q;
  logic          guardDone;
  logic          cmdPending;
  logic          slotFree;
  logic          cmdTake;
  logic          ready_d;

  assign cmdPending = cmdRespValid || cmdBusy;
  assign slotFree   = !outValid || outReady;
  assign guardDone  = (guardCnt_q == GW'(GUARD_CYCLES - 1)) && !txBusy;
  assign cmdTake    = cmdRespValid && cmdRespReady;
  assign fifoPop    = (state_q == fault_signal_pkg::SRC_DATA) && fifoValid && slotFree
                      && !cmdPending && !holdActive;

  always_comb begin
    state_d = state_q;
    case (state_q)
      fault_signal_pkg::SRC_CMD: begin
        if (fifoValid && !holdActive && !cmdPending && !outValid) begin
          state_d = fault_signal_pkg::SRC_TO_DATA;
        end
      end
      fault_signal_pkg::SRC_TO_DATA: begin
        if (cmdPending) begin
          state_d = fault_signal_pkg::SRC_CMD;
        end else if (guardDone) begin
          state_d = fault_signal_pkg::SRC_DATA;
        end
      end
      fault_signal_pkg::SRC_DATA: begin
        if (cmdPending && !outValid) begin
          state_d = fault_signal_pkg::SRC_TO_CMD;
        end
      end
      fault_signal_pkg::SRC_TO_CMD: begin
        if (!cmdPending && fifoValid && !holdActive) begin
          state_d = fault_signal_pkg::SRC_DATA;
        end else if (guardDone) begin
          state_d = fault_signal_pkg::SRC_CMD;
        end
      end
      default: begin
        state_d = fault_signal_pkg::SRC_CMD;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= fault_signal_pkg::SRC_CMD;
    end else begin
      state_q <= state_d;
    end
  end

  // Guard time runs only once the transmitter has sent its stop bit.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      guardCnt_q <= '0;
    end else if (state_q == fault_signal_pkg::SRC_TO_DATA
                 || state_q == fault_signal_pkg::SRC_TO_CMD) begin
      if (txBusy || outValid) begin
        guardCnt_q <= '0;
      end else if (!guardDone) begin
        guardCnt_q <= guardCnt_q + 1'b1;
      end
    end else begin
      guardCnt_q <= '0;
    end
  end

  // The line only moves when the state settles on the other source.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      responseSourceLine <= 1'b0;
    end else if (state_d == fault_signal_pkg::SRC_DATA) begin
      responseSourceLine <= 1'b1;
    end else if (state_d == fault_signal_pkg::SRC_CMD) begin
      responseSourceLine <= 1'b0;
    end
  end

  // ***************************************************************
  // Output byte register
  // ***************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      outValid <= 1'b0;
      outData  <= 8'h00;
    end else if (cmdTake) begin
      outValid <= 1'b1;
      outData  <= cmdRespData;
    end else if (fifoPop) begin
      outValid <= 1'b1;
      outData  <= fifoData;
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

  // Response bytes are only accepted while the line already shows a response.
  assign ready_d = (state_d == fault_signal_pkg::SRC_CMD)
                   && (state_q == fault_signal_pkg::SRC_CMD)
                   && !((cmdTake || fifoPop || outValid) && !outReady);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmdRespReady <= 1'b0;
    end else begin
      cmdRespReady <= ready_d && !cmdTake;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lineStatusRegister <= '0;
    end else begin
      lineStatusRegister <= '0;
      lineStatusRegister[fault_signal_pkg::LSTAT_ALERT_BIT] <= alert_d;
      lineStatusRegister[fault_signal_pkg::LSTAT_SOURCE_BIT] <=
        (state_d == fault_signal_pkg::SRC_DATA) ? 1'b1 :
        (state_d == fault_signal_pkg::SRC_CMD) ? 1'b0 : responseSourceLine;
      lineStatusRegister[fault_signal_pkg::LSTAT_HOLD_BIT] <= holdActive;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_legacy_set;
    @(posedge sys_clk) disable iff (!resetn)
    (legacyMode && legacyEvent && ((eventCode & legacyFaultMask) != 8'h00))
      |=> faultAlertLine;
  endproperty
  a_legacy_set: assert property (p_legacy_set) else $error("legacy alert not set");

  property p_legacy_hold;
    @(posedge sys_clk) disable iff (!resetn)
    (legacyMode && legacyAlert_q && !legacyCodeRead) |=> faultAlertLine;
  endproperty
  a_legacy_hold: assert property (p_legacy_hold) else $error("legacy alert moved");

  property p_legacy_clear;
    @(posedge sys_clk) disable iff (!resetn)
    (legacyMode && legacyCodeRead && !legacyEvent) |=> (legacyMode -> !faultAlertLine);
  endproperty
  a_legacy_clear: assert property (p_legacy_clear) else $error("read did not clear");

  property p_code_store;
    @(posedge sys_clk) disable iff (!resetn)
    legacyEvent |=> legacyFaultCode == $past(eventCode);
  endproperty
  a_code_store: assert property (p_code_store) else $error("fault code not stored");

  property p_flag_mirror;
    @(posedge sys_clk) disable iff (!resetn)
    legacyEvent |=> (extendedFaultFlags & $past(eventFlags)) == $past(eventFlags);
  endproperty
  a_flag_mirror: assert property (p_flag_mirror) else $error("flag not mirrored");

  property p_ext_alert;
    @(posedge sys_clk) disable iff (!resetn)
    !legacyMode |=> faultAlertLine == (($past(extendedFaultMask) & extendedFaultFlags) != '0);
  endproperty
  a_ext_alert: assert property (p_ext_alert) else $error("extended alert wrong");

  property p_status_alert;
    @(posedge sys_clk) disable iff (!resetn)
    lineStatusRegister[fault_signal_pkg::LSTAT_ALERT_BIT] == faultAlertLine;
  endproperty
  a_status_alert: assert property (p_status_alert) else $error("status bit differs");

  property p_source_match;
    @(posedge sys_clk) disable iff (!resetn)
    (cmdTake |=> !responseSourceLine) and (fifoPop |=> responseSourceLine);
  endproperty
  a_source_match: assert property (p_source_match) else $error("byte on wrong source");

  property p_guard_before_data;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(responseSourceLine) |-> $past(guardDone) || $past(state_q) == fault_signal_pkg::SRC_DATA
      || $past(state_q) == fault_signal_pkg::SRC_TO_CMD;
  endproperty
  a_guard_before_data: assert property (p_guard_before_data) else $error("no guard");

  property p_hold;
    @(posedge sys_clk) disable iff (!resetn)
    holdActive |-> !fifoPop;
  endproperty
  a_hold: assert property (p_hold) else $error("data sent during hold");

endmodule : host_fault_and_response_signalling

// ---- tb/serial_host_model.sv ----
// Serial transmitter and host receiver model that records the first 32 output bytes.
`timescale 1ns/100ps
module serial_host_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Byte stream from the block
  input  wire logic       outValid,
  input  wire logic [7:0] outData,
  input  wire logic       responseSourceLine,
  input  wire logic       slow,
  output logic            outReady,
  output logic            txBusy
);
  int         busyCnt;
  int         gotN;
  logic [7:0] gotData [0:31];
  logic       gotSrc  [0:31];

  // Each byte keeps the shifter busy for a byte time; slow mode stalls longer.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busyCnt <= 0;
      gotN    <= 0;
    end else if (busyCnt != 0) begin
      busyCnt <= busyCnt - 1;
    end else if (outValid && gotN < 32) begin
      gotData[gotN] <= outData;
      gotSrc[gotN]  <= responseSourceLine;
      gotN          <= gotN + 1;
      busyCnt       <= slow ? 40 : 10;
    end
  end
  assign outReady = (busyCnt == 0);
  assign txBusy   = (busyCnt != 0);
endmodule : serial_host_model

// ---- tb/test_host_fault_and_response_signalling.sv ----
// Self-checking bench for the fault alert and response source block.
`timescale 1ns/100ps
module test_host_fault_and_response_signalling;
  localparam int GUARD = 20;
  typedef struct packed {int ev; logic [7:0] lm; logic [15:0] em; logic [7:0] code; logic al;} row_t;
  localparam row_t ROWS [0:9] = '{
    '{0, 8'hFF, 16'h0000, 8'h08, 1'b1}, '{1, 8'h08, 16'h0000, 8'h09, 1'b1},
    '{2, 8'h10, 16'h0000, 8'h13, 1'b1}, '{3, 8'h10, 16'h0000, 8'h20, 1'b0},
    '{4, 8'h60, 16'h0000, 8'h40, 1'b1}, '{5, 8'h40, 16'h0000, 8'h42, 1'b1},
    '{6, 8'h60, 16'h0000, 8'h43, 1'b1}, '{7, 8'h08, 16'h0000, 8'h44, 1'b0},
    '{8, 8'h00, 16'h0100, 8'h44, 1'b1}, '{9, 8'h00, 16'h0100, 8'h44, 1'b0}};
  logic        sys_clk, resetn, legacyCodeRead, extFlagWrite, cmdSelectN, cmdBusy;
  logic        cmdRespValid, cmdRespReady, rxValid, rxReady, slow, faultAlertLine;
  logic        outValid, outReady, txBusy, responseSourceLine, srcPrev;
  logic [11:0] faultEvents;
  logic [7:0]  legacyFaultMask, holdReceivedDuringCommand, cmdRespData, rxData, outData;
  logic [7:0]  legacyFaultCode, lineStatusRegister;
  logic [15:0] extendedFaultMask, extFlagWdata, extendedFaultFlags;
  int          errors, compares, quiet, base, n;
  bit          ok;

  host_fault_and_response_signalling #(.GUARD_CYCLES(GUARD)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .faultEvents(faultEvents),
    .legacyFaultMask(legacyFaultMask), .extendedFaultMask(extendedFaultMask),
    .legacyCodeRead(legacyCodeRead), .extFlagWrite(extFlagWrite),
    .extFlagWdata(extFlagWdata), .faultAlertLine(faultAlertLine),
    .legacyFaultCode(legacyFaultCode), .extendedFaultFlags(extendedFaultFlags),
    .lineStatusRegister(lineStatusRegister), .cmdSelectN(cmdSelectN),
    .holdReceivedDuringCommand(holdReceivedDuringCommand), .cmdBusy(cmdBusy),
    .cmdRespValid(cmdRespValid), .cmdRespData(cmdRespData), .cmdRespReady(cmdRespReady),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .outValid(outValid),
    .outData(outData), .outReady(outReady), .txBusy(txBusy),
    .responseSourceLine(responseSourceLine));
  serial_host_model host (
    .sys_clk(sys_clk), .resetn(resetn), .outValid(outValid), .outData(outData),
    .responseSourceLine(responseSourceLine), .slow(slow), .outReady(outReady),
    .txBusy(txBusy));

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic tally_and_finish;
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : tick

  task automatic fire(input int ev);
    faultEvents = 12'h001 << ev;
    tick(1);
    faultEvents = 12'h000;
    tick(2);
  endtask : fire

  task automatic wrFlags(input logic [15:0] v);
    extFlagWrite = 1'b1;
    extFlagWdata = v;
    tick(1);
    extFlagWrite = 1'b0;
    tick(2);
  endtask : wrFlags

  task automatic push(input logic [7:0] d, output bit taken);
    rxValid = 1'b1;
    rxData  = d;
    taken   = rxReady;
    tick(1);
  endtask : push

  task automatic resp(input logic [7:0] d);
    cmdRespData  = d;
    cmdRespValid = 1'b1;
    for (int i = 0; i < 300 && cmdRespReady !== 1'b1; i++) tick(1);
    tick(1);
    cmdRespValid = 1'b0;
    tick(1);
  endtask : resp

  task automatic waitBytes(input int k);
    for (int i = 0; i < 3000 && host.gotN < k; i++) tick(1);
    chk("bytes", 16'(host.gotN >= k), 16'h0001);
  endtask : waitBytes

  task automatic chkByte(input int k, input logic [7:0] d, input logic s);
    chk("byte", 16'(host.gotData[k]), 16'(d));
    chk("source", 16'(host.gotSrc[k]), 16'(s));
  endtask : chkByte

  // ***************************************************************
  // Clock, watchdog and source line guard monitor
  // ***************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end

  always @(negedge sys_clk) begin
    if (!resetn) begin
      quiet = 0;
    end else begin
      if (responseSourceLine !== srcPrev) chk("guard", 16'(quiet >= GUARD), 16'h0001);
      quiet = (txBusy || outValid) ? 0 : quiet + 1;
    end
    srcPrev = responseSourceLine;
  end

  // ***************************************************************
  // Sequence
  // ***************************************************************
  initial begin
    {resetn, legacyCodeRead, extFlagWrite, cmdBusy, cmdRespValid, rxValid, slow} = '0;
    {faultEvents, legacyFaultMask, extendedFaultMask, extFlagWdata} = '0;
    {holdReceivedDuringCommand, cmdRespData, rxData} = '0;
    cmdSelectN = 1'b1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1'b1;
    tick(1);
    chk("alert", 16'(faultAlertLine), 16'h0000);
    chk("code", 16'(legacyFaultCode), 16'h0000);
    chk("flags", extendedFaultFlags, 16'h0000);
    foreach (ROWS[i]) begin
      legacyFaultMask   = ROWS[i].lm;
      extendedFaultMask = ROWS[i].em;
      legacyCodeRead    = 1'b1;
      wrFlags(16'h0000);
      legacyCodeRead    = 1'b0;
      fire(ROWS[i].ev);
      chk("code", 16'(legacyFaultCode), 16'(ROWS[i].code));
      chk("flags", extendedFaultFlags, 16'h0001 << ROWS[i].ev);
      chk("alert", 16'(faultAlertLine), 16'(ROWS[i].al));
      chk("status", 16'(lineStatusRegister[0]), 16'(ROWS[i].al));
    end
    legacyFaultMask = 8'hFF;
    faultEvents     = 12'h001;
    tick(1);
    fire(6);
    chk("code", 16'(legacyFaultCode), 16'h0043);
    legacyFaultMask = 8'h04;
    wrFlags(16'h0000);
    chk("alert", 16'(faultAlertLine), 16'h0001);
    legacyCodeRead = 1'b1;
    fire(13);
    legacyCodeRead = 1'b0;
    chk("alert", 16'(faultAlertLine), 16'h0000);
    legacyFaultMask   = 8'h00;
    extendedFaultMask = 16'h0003;
    wrFlags(16'h0003);
    chk("alert", 16'(faultAlertLine), 16'h0001);
    wrFlags(16'h0002);
    chk("alert", 16'(faultAlertLine), 16'h0001);
    wrFlags(16'h0004);
    chk("alert", 16'(faultAlertLine), 16'h0000);
    extendedFaultMask = 16'h0004;
    tick(2);
    chk("alert", 16'(faultAlertLine), 16'h0001);
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    tick(1);
    chk("alert", 16'(faultAlertLine), 16'h0000);
    chk("code", 16'(legacyFaultCode), 16'h0000);
    chk("flags", extendedFaultFlags, 16'h0000);
    legacyFaultMask = 8'h02;
    tick(2);
    chk("alert", 16'(faultAlertLine), 16'h0000);
    base = host.gotN;
    for (int i = 0; i < 3; i++) push(8'h50 + 8'(i), ok);
    rxValid = 1'b0;
    waitBytes(base + 3);
    for (int i = 0; i < 3; i++) chkByte(base + i, 8'h50 + 8'(i), 1'b1);
    cmdSelectN = 1'b0;
    holdReceivedDuringCommand = 8'h01;
    slow = 1'b1;
    tick(1);
    base = host.gotN;
    n    = 0;
    for (int i = 0; i < 9; i++) begin
      push(8'h10 + 8'(i), ok);
      n += ok;
    end
    rxValid = 1'b0;
    chk("fill", 16'(n), 16'h0008);
    resp(8'hA1);
    resp(8'hA2);
    tick(150);
    chk("held", 16'(host.gotN - base), 16'h0002);
    chk("status", 16'(lineStatusRegister), 16'h0004);
    cmdSelectN = 1'b1;
    waitBytes(base + 10);
    chkByte(base, 8'hA1, 1'b0);
    chkByte(base + 1, 8'hA2, 1'b0);
    for (int i = 0; i < 8; i++) chkByte(base + 2 + i, 8'h10 + 8'(i), 1'b1);
    chk("status", 16'(lineStatusRegister), 16'h0002);
    holdReceivedDuringCommand = 8'h00;
    cmdSelectN = 1'b0;
    cmdBusy    = 1'b1;
    tick(100);
    base = host.gotN;
    push(8'h30, ok);
    push(8'h31, ok);
    rxValid = 1'b0;
    resp(8'hB1);
    cmdBusy = 1'b0;
    waitBytes(base + 3);
    chkByte(base, 8'hB1, 1'b0);
    chkByte(base + 1, 8'h30, 1'b1);
    chkByte(base + 2, 8'h31, 1'b1);
    tally_and_finish();
  end
endmodule : test_host_fault_and_response_signalling
